// *** adc_trigger_timer_pair_tb_top.sv ***
/*
 * Testbench for the timer pair: APB driver, type 1 and type 2 timing,
 * count clock selection, stop and power-off.
 * Assumes the pair and the converter model share pclk.
 */
`timescale 1ns/1ns

module adc_trigger_timer_pair_tb_top;
	import adctt_pkg::*;

	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr  = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rd;
	logic        pready, pslverr, err, mlvl, moe, slvl, soe, mint, sint;
	int          miscompares = 0, checked = 0, cyc = 0, t0;
	int          m_t[$];

	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (mint === 1'b1) begin
			m_t.push_back(cyc);
		end
	end

	adctt_top adctt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.master_out_level(mlvl), .master_out_enable(moe), .slave_out_level(slvl),
		.slave_out_enable(soe), .master_interrupt(mint), .slave_interrupt(sint));

	adctt_conv_model adctt_conv_model_inst (.pclk(pclk), .presetn(presetn),
		.slave_interrupt(sint), .master_out_level(mlvl));

	// ----------
	// Bus and compare
	// ----------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string s);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
		end
	endtask

	task automatic chk_time(input int got, input int exp, input string s);
		checked++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %0d want %0d", $time, s, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string s);
		apb(1'b0, a, 32'h0);
		chk_reg(rd, exp, s);
	endtask

	// ----------
	// Scenarios
	// ----------
	task automatic s_unit_off;
		apb(1'b1, ADDR_MASTER_DATA, 32'h5);
		apb(1'b1, ADDR_UNIT_CTRL, 32'h3);
		rd_chk(ADDR_MASTER_DATA, 32'h0, "write while off");
		apb(1'b0, 8'h34, 32'h0);
		chk_reg({31'h0, err}, 32'h1, "unmapped error");
		chk_reg(rd, 32'h0, "unmapped data");
	endtask

	task automatic s_type1(input int p, input logic [1:0] sel);
		int          sp;
		logic [31:0] psc, c1;
		sp  = 1 << p;
		psc = (32'hffff & ~(32'hf << (4 * sel))) | (p << (4 * sel));
		apb(1'b1, ADDR_PRESCALER, psc);
		apb(1'b1, ADDR_MASTER_MODE, {28'h0, sel, 2'h1});
		apb(1'b1, ADDR_SLAVE_MODE, {28'h0, sel, 2'h0});
		apb(1'b1, ADDR_MASTER_DATA, 32'h2);
		apb(1'b1, ADDR_SLAVE_DATA, 32'h1);
		m_t.delete();
		adctt_conv_model_inst.trig_t.delete();
		apb(1'b1, ADDR_START_TRIG, 32'h3);
		t0 = cyc;
		rd_chk(ADDR_START_TRIG, 32'h0, "trigger readback");
		rd_chk(ADDR_ENABLE_FLAG, 32'h3, "enable flags");
		apb(1'b0, ADDR_MASTER_CNT, 32'h0);
		chk_reg(rd[31:2], 30'h0, "count in range");
		repeat (12 * sp) @(posedge pclk);
		chk_time(m_t[0] - t0 < 3 * sp + 3, 1, "start interrupt");
		chk_time(m_t[2] - m_t[1], 3 * sp, "master period");
		chk_time(m_t[3] - m_t[2], 3 * sp, "prescaled period");
		chk_time(adctt_conv_model_inst.trig_t[1] - m_t[1], 2 * sp, "slave delay");
		chk_time(adctt_conv_model_inst.trig_t[2] - adctt_conv_model_inst.trig_t[1],
			3 * sp, "one shot per period");
		apb(1'b1, ADDR_STOP_TRIG, 32'h3);
		rd_chk(ADDR_ENABLE_FLAG, 32'h0, "stop flags");
		apb(1'b0, ADDR_MASTER_CNT, 32'h0);
		c1 = rd;
		repeat (4 * sp) @(posedge pclk);
		rd_chk(ADDR_MASTER_CNT, c1, "master hold");
	endtask

	task automatic s_type2;
		int k, ms, d, du;
		apb(1'b1, ADDR_PRESCALER, 32'h0);
		apb(1'b1, ADDR_MASTER_MODE, 32'h2);
		apb(1'b1, ADDR_SLAVE_MODE, 32'h2);
		apb(1'b1, ADDR_MASTER_DATA, 32'h4);
		apb(1'b1, ADDR_OUT_CTRL, 32'h2);
		apb(1'b1, ADDR_OUT_CTRL, 32'h3);
		@(posedge pclk);
		chk_reg({28'h0, soe, slvl, moe, mlvl}, 32'h3, "output pins");
		for (int j = 0; j < 2; j++) begin
			d = 2 + j;
			du = (5 - d) * 2;
			apb(1'b1, ADDR_SLAVE_DATA, d);
			if (j == 0) begin
				m_t.delete();
				apb(1'b1, ADDR_START_TRIG, 32'h3);
				t0 = cyc;
			end
			repeat (24) @(posedge pclk);
			if (j == 0) begin
				chk_time(m_t[0] - t0 > 4, 1, "no start interrupt");
			end
			m_t.delete();
			adctt_conv_model_inst.trig_t.delete();
			adctt_conv_model_inst.trig_lvl.delete();
			repeat (30) @(posedge pclk);
			k = (adctt_conv_model_inst.trig_lvl[0] === 1'b1) ? 0 : 1;
			chk_time(adctt_conv_model_inst.trig_t[k + 1] - adctt_conv_model_inst.trig_t[k],
				du, "down to up");
			chk_time(adctt_conv_model_inst.trig_t[k + 2] - adctt_conv_model_inst.trig_t[k + 1],
				10 - du, "up to down");
			chk_reg(adctt_conv_model_inst.trig_lvl[k], 1'b1, "level in down");
			chk_reg(adctt_conv_model_inst.trig_lvl[k + 1], 1'b0, "level in up");
			chk_time(m_t[1] - m_t[0], 5, "master half carrier");
			ms = 0;
			foreach (m_t[i]) begin
				if (m_t[i] < adctt_conv_model_inst.trig_t[k + 2]) begin
					ms = m_t[i];
				end
			end
			chk_time(adctt_conv_model_inst.trig_t[k + 2] - ms,
				d + 1, "carrier to trigger");
		end
		apb(1'b1, ADDR_STOP_TRIG, 32'h3);
		apb(1'b1, ADDR_UNIT_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		chk_reg(mlvl, 1'b0, "level after power off");
		apb(1'b1, ADDR_UNIT_CTRL, 32'h3);
		rd_chk(ADDR_OUT_CTRL, 32'h0, "outputs after power off");
		rd_chk(ADDR_MASTER_CNT, 32'h0, "counter after power off");
		rd_chk(ADDR_MASTER_DATA, 32'h0, "data after power off");
	endtask

	task automatic close_out;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		s_unit_off();
		s_type1(0, 2'h0);
		s_type1(1, 2'h1);
		s_type1(2, 2'h2);
		s_type1(1, 2'h3);
		s_type2();
		close_out();
	end

	initial begin
		#(40 * 5000);
		miscompares++;
		close_out();
	end
endmodule

// *** adctt_conv_model.sv ***
/*
 * Converter start model: logs every slave trigger pulse with its cycle
 * number and the master output level seen in that cycle.
 * Assumes pulses are synchronous to pclk and last one cycle.
 */
`timescale 1ns/1ns

module adctt_conv_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Trigger side
	input wire logic slave_interrupt,
	input wire logic master_out_level
);
	int   cyc = 0;
	int   trig_t[$];
	logic trig_lvl[$];

	// ----------
	// Trigger log
	// ----------
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (presetn === 1'b1 && slave_interrupt === 1'b1) begin
			trig_t.push_back(cyc);
			trig_lvl.push_back(master_out_level);
		end
	end
endmodule

// *** adctt_pkg.sv ***
/*
 * Package for the ADC trigger timer pair: register map, field layout,
 * reset values and the packed carriers of the configuration words.
 * Assumes a 32-bit APB register bus with one aligned word per register.
 */
package adctt_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_UNIT_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_PRESCALER   = 8'h04;
	localparam logic [7:0] ADDR_START_TRIG  = 8'h08;
	localparam logic [7:0] ADDR_STOP_TRIG   = 8'h0c;
	localparam logic [7:0] ADDR_ENABLE_FLAG = 8'h10;
	localparam logic [7:0] ADDR_MASTER_MODE = 8'h14;
	localparam logic [7:0] ADDR_SLAVE_MODE  = 8'h18;
	localparam logic [7:0] ADDR_MASTER_DATA = 8'h1c;
	localparam logic [7:0] ADDR_SLAVE_DATA  = 8'h20;
	localparam logic [7:0] ADDR_MASTER_CNT  = 8'h24;
	localparam logic [7:0] ADDR_SLAVE_CNT   = 8'h28;
	localparam logic [7:0] ADDR_OUT_CTRL    = 8'h2c;
	localparam logic [7:0] ADDR_STATUS      = 8'h30;

	// ----------------------------------------------------------------
	// Field positions and widths
	// ----------------------------------------------------------------
	localparam int BIT_UNIT_CLK   = 0;
	localparam int BIT_UNIT_PWR   = 1;
	localparam int BIT_MASTER_TRG = 0;
	localparam int BIT_SLAVE_TRG  = 1;
	localparam int PSC_FIELD_W    = 4;
	localparam int CNT_W          = 16;
	localparam int CFG_W          = 4;
	localparam int OUT_W          = 6;

	// ----------------------------------------------------------------
	// Reset and terminal values
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] CNT_ZERO  = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
	localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;
	localparam logic [15:0]      PSC_RESET = 16'h0000;
	localparam logic [1:0]       UNIT_RESET = 2'h0;

	// Count clock choices: each of the master and slave channels selects any one of a, b, c and d
	typedef enum logic [1:0] {
		ADCTT_CK_A = 2'h0,
		ADCTT_CK_B = 2'h1,
		ADCTT_CK_C = 2'h2,
		ADCTT_CK_D = 2'h3
	} adctt_clk_e;

	// Channel mode word
	typedef struct packed {
		adctt_clk_e clk_sel;
		logic       func_type2;
		logic       start_interrupt_mode_bit;
	} adctt_mode_s;

	// Output control word
	typedef struct packed {
		logic slave_output_mode;
		logic slave_output_level;
		logic slave_output_enable;
		logic master_output_mode;
		logic master_output_level;
		logic master_output_enable;
	} adctt_out_s;

	localparam adctt_mode_s MODE_RESET = '0;
	localparam adctt_out_s  OUT_RESET  = '0;

endpackage

// *** adctt_top.sv ***
/*
 * ADC trigger timer pair: a master interval channel and a slave duty
 * channel whose interrupt starts an A/D conversion, with APB registers.
 * Assumes a single 25 MHz pclk, inputs synchronous to it, and an APB
 * master that keeps each request steady until the access completes.
 */
`timescale 1ns/1ns

module adctt_top (
	// Clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Timer outputs
	output logic                             master_out_level,
	output logic                             master_out_enable,
	output logic                             slave_out_level,
	output logic                             slave_out_enable,
	output logic                             master_interrupt,
	output logic                             slave_interrupt
);
	import adctt_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// One-cycle enable when the low sel bits of the divider are all ones
	function automatic logic psc_tick(input logic [15:0] cnt, input logic [3:0] sel);
		logic [15:0] mask;
		mask = 16'hffff >> (5'h10 - {1'b0, sel});
		if (sel == 4'h0) begin
			mask = 16'h0000;
		end
		return (cnt & mask) == mask;
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [1:0]        unit_q;
	logic [15:0]       psc_q;
	adctt_mode_s       mcfg_q;
	adctt_mode_s       scfg_q;
	logic [CNT_W-1:0]  mper_q;
	logic [CNT_W-1:0]  sduty_q;
	adctt_out_s        out_q;
	logic [15:0]       div_q;
	logic              m_en_q;
	logic              s_en_q;
	logic              m_pend_q;
	logic              s_pend_q;
	logic              s_run_q;
	logic              s_up_q;
	logic [CNT_W-1:0]  m_cnt_q;
	logic [CNT_W-1:0]  s_cnt_q;
	logic [CNT_W-1:0]  m_per_sh_q;
	logic [CNT_W-1:0]  s_duty_sh_q;
	logic              m_irq_q;
	logic              s_irq_q;
	logic [31:0]       prdata_q;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	wire        setup_ph  = psel & ~penable;
	wire        access_ph = psel & penable;
	wire        unit_off  = ~unit_q[BIT_UNIT_CLK] & ~unit_q[BIT_UNIT_PWR];
	wire        unit_run  = unit_q[BIT_UNIT_CLK];
	wire        hit       = (paddr <= ADDR_STATUS) && (paddr[1:0] == 2'h0);
	wire        wr        = access_ph & pwrite & hit;
	wire        wr_reg    = wr & ~unit_off;
	wire        wr_unit   = wr & (paddr == ADDR_UNIT_CTRL);
	wire        wr_psc    = wr_reg & (paddr == ADDR_PRESCALER);
	wire        wr_start  = wr_reg & (paddr == ADDR_START_TRIG);
	wire        wr_stop   = wr_reg & (paddr == ADDR_STOP_TRIG);
	wire        wr_mmode  = wr_reg & (paddr == ADDR_MASTER_MODE);
	wire        wr_smode  = wr_reg & (paddr == ADDR_SLAVE_MODE);
	wire        wr_mdata  = wr_reg & (paddr == ADDR_MASTER_DATA);
	wire        wr_sdata  = wr_reg & (paddr == ADDR_SLAVE_DATA);
	wire        wr_out    = wr_reg & (paddr == ADDR_OUT_CTRL);
	wire        m_stop    = wr_stop & pwdata[BIT_MASTER_TRG];
	wire        s_stop    = wr_stop & pwdata[BIT_SLAVE_TRG];
	wire        m_start   = wr_start & pwdata[BIT_MASTER_TRG] & ~m_stop;
	wire        s_start   = wr_start & pwdata[BIT_SLAVE_TRG] & ~s_stop;

	// Read selection; trigger registers always read as zero
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (paddr == ADDR_UNIT_CTRL) begin
			rd_mux = {30'h0, unit_q};
		end else if (paddr == ADDR_PRESCALER) begin
			rd_mux = {16'h0, psc_q};
		end else if (paddr == ADDR_ENABLE_FLAG) begin
			rd_mux = {30'h0, s_en_q, m_en_q};
		end else if (paddr == ADDR_MASTER_MODE) begin
			rd_mux = {28'h0, mcfg_q};
		end else if (paddr == ADDR_SLAVE_MODE) begin
			rd_mux = {28'h0, scfg_q};
		end else if (paddr == ADDR_MASTER_DATA) begin
			rd_mux = {16'h0, mper_q};
		end else if (paddr == ADDR_SLAVE_DATA) begin
			rd_mux = {16'h0, sduty_q};
		end else if (paddr == ADDR_MASTER_CNT) begin
			rd_mux = {16'h0, m_cnt_q};
		end else if (paddr == ADDR_SLAVE_CNT) begin
			rd_mux = {16'h0, s_cnt_q};
		end else if (paddr == ADDR_OUT_CTRL) begin
			rd_mux = {26'h0, out_q};
		end else if (paddr == ADDR_STATUS) begin
			rd_mux = {28'h0, s_pend_q, m_pend_q, s_run_q, s_up_q};
		end
	end

	// ----------------------------------------------------------------
	// Count clocks
	// ----------------------------------------------------------------
	// four prescaled count clocks, a/b low group, c/d high group
	wire [3:0] ck_tick;
	assign ck_tick[0] = unit_run & psc_tick(div_q, psc_q[3:0]);
	assign ck_tick[1] = unit_run & psc_tick(div_q, psc_q[7:4]);
	assign ck_tick[2] = unit_run & psc_tick(div_q, psc_q[11:8]);
	assign ck_tick[3] = unit_run & psc_tick(div_q, psc_q[15:12]);
	wire m_tick = ck_tick[mcfg_q.clk_sel];
	wire s_tick = ck_tick[scfg_q.clk_sel];

	// ----------------------------------------------------------------
	// Master channel events
	// ----------------------------------------------------------------
	// start load at the first count clock, interrupt only by mode bit
	wire m_load = m_en_q & m_pend_q & m_tick;
	// on the count clock after zero, interrupt and reload
	wire m_wrap = m_en_q & ~m_pend_q & m_tick & (m_cnt_q == CNT_ZERO);
	wire m_dec  = m_en_q & ~m_pend_q & m_tick & (m_cnt_q != CNT_ZERO);
	wire m_fire = m_wrap | (m_load & mcfg_q.start_interrupt_mode_bit);

	// ----------------------------------------------------------------
	// Slave channel events
	// ----------------------------------------------------------------
	wire type2     = scfg_q.func_type2;
	wire s_active  = s_en_q & ~unit_off;
	// master wraps alternate down and up status
	wire s_flip_up = type2 & s_active & m_wrap & ~s_up_q;
	wire s_carrier = type2 & s_active & m_wrap & s_up_q;
	wire s_load2   = type2 & s_active & s_pend_q & s_tick;
	// master interrupt loads the one-count slave
	wire s_load1   = ~type2 & s_active & m_fire;
	wire s_count   = s_active & s_run_q & s_tick & ~s_pend_q;
	wire [16:0] up_end = {1'b0, m_per_sh_q} + 17'h00001;
	// down status ends one count clock after reaching zero
	wire s_end_dn  = s_count & (~type2 | ~s_up_q) & (s_cnt_q == CNT_ZERO);
	// up status ends one count clock after the count reaches master period plus one
	wire s_end_up  = s_count & type2 & s_up_q & ({1'b0, s_cnt_q} == up_end);
	// A status flip or carrier reload in the same tick must not swallow an end of count
	wire s_fire    = (s_end_dn & ~s_load1) | s_end_up;

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	// unit off holds every channel register at its initial value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unit_q  <= UNIT_RESET;
			psc_q   <= PSC_RESET;
			mcfg_q  <= MODE_RESET;
			scfg_q  <= MODE_RESET;
			mper_q  <= CNT_ZERO;
			sduty_q <= CNT_ZERO;
		end else begin
			if (wr_unit) unit_q <= pwdata[1:0];
			if (unit_off) begin
				psc_q   <= PSC_RESET;
				mcfg_q  <= MODE_RESET;
				scfg_q  <= MODE_RESET;
				mper_q  <= CNT_ZERO;
				sduty_q <= CNT_ZERO;
			end else begin
				if (wr_psc) psc_q <= pwdata[15:0];
				if (wr_mmode) mcfg_q <= adctt_mode_s'(pwdata[CFG_W-1:0]);
				if (wr_smode) scfg_q <= adctt_mode_s'(pwdata[CFG_W-1:0]);
				if (wr_mdata) mper_q <= pwdata[CNT_W-1:0];
				if (wr_sdata) sduty_q <= pwdata[CNT_W-1:0];
			end
		end
	end

	// Output control; master level toggles by hardware on master interrupts while master output is enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= OUT_RESET;
		end else if (unit_off) begin
			out_q <= OUT_RESET;
		end else if (wr_out) begin
			out_q <= adctt_out_s'(pwdata[OUT_W-1:0]);
		end else if (m_fire & out_q.master_output_enable) begin
			// toggling the preset level marks down high, up low
			out_q.master_output_level <= ~out_q.master_output_level;
		end
	end

	// Free-running prescaler divider
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= 16'h0000;
		end else if (!unit_run) begin
			div_q <= 16'h0000;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// Master channel
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_en_q     <= 1'b0;
			m_pend_q   <= 1'b0;
			m_cnt_q    <= CNT_ZERO;
			m_per_sh_q <= CNT_ZERO;
			m_irq_q    <= 1'b0;
		end else if (unit_off) begin
			m_en_q     <= 1'b0;
			m_pend_q   <= 1'b0;
			m_cnt_q    <= CNT_ZERO;
			m_per_sh_q <= CNT_ZERO;
			m_irq_q    <= 1'b0;
		end else begin
			m_irq_q <= m_fire;
			// stop clears the flag and freezes the count
			if (m_stop) begin
				m_en_q   <= 1'b0;
				m_pend_q <= 1'b0;
			end else if (m_start) begin
				m_en_q   <= 1'b1;
				m_pend_q <= 1'b1;
			end else if (m_load) begin
				m_pend_q <= 1'b0;
			end
			// reload period data at zero, else count down
			if (m_load | m_wrap) begin
				m_cnt_q    <= mper_q;
				m_per_sh_q <= mper_q;
			end else if (m_dec) begin
				m_cnt_q <= m_cnt_q - 16'h0001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Slave channel
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_en_q      <= 1'b0;
			s_pend_q    <= 1'b0;
			s_run_q     <= 1'b0;
			s_up_q      <= 1'b0;
			s_cnt_q     <= CNT_ZERO;
			s_duty_sh_q <= CNT_ZERO;
			s_irq_q     <= 1'b0;
		end else if (unit_off) begin
			s_en_q      <= 1'b0;
			s_pend_q    <= 1'b0;
			s_run_q     <= 1'b0;
			s_up_q      <= 1'b0;
			s_cnt_q     <= CNT_ZERO;
			s_duty_sh_q <= CNT_ZERO;
			s_irq_q     <= 1'b0;
		end else begin
			s_irq_q <= s_fire;
			if (s_stop) begin
				s_en_q   <= 1'b0;
				s_pend_q <= 1'b0;
				s_run_q  <= 1'b0;
			end else if (s_start) begin
				s_en_q   <= 1'b1;
				s_pend_q <= type2;
				s_run_q  <= 1'b0;
			end
			// master load opens down status, each wrap flips it
			if (m_load) begin
				s_up_q <= 1'b0;
			end else if (m_wrap) begin
				s_up_q <= ~s_up_q;
			end
			if (s_load1 | s_load2 | s_carrier) begin
				// first count clock loads duty, then down count
				// up-status master interrupt reloads the duty
				// duty is sampled at each of these loads, never at the flip to up status
				s_cnt_q     <= sduty_q;
				s_duty_sh_q <= sduty_q;
				s_run_q     <= 1'b1;
				if (s_load2) s_pend_q <= 1'b0;
			end else if (s_flip_up) begin
				s_cnt_q <= s_duty_sh_q;
				s_run_q <= 1'b1;
			end else if (s_fire) begin
				// one-count duty stops until the next trigger
				s_run_q <= 1'b0;
			end else if (s_count) begin
				// counts never wrap past the 16-bit ends
				if (type2 & s_up_q) begin
					if (s_cnt_q != CNT_MAX) s_cnt_q <= s_cnt_q + CNT_ONE;
				end else if (s_cnt_q != CNT_ZERO) begin
					s_cnt_q <= s_cnt_q - CNT_ONE;
				end
			end
		end
	end

	// APB read data, captured in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (setup_ph & ~pwrite) begin
			prdata_q <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign prdata            = prdata_q;
	assign pready            = 1'b1;
	assign pslverr           = access_ph & ~hit;
	assign master_out_level  = out_q.master_output_level;
	assign master_out_enable = out_q.master_output_enable;
	assign slave_out_level   = out_q.slave_output_level;
	assign slave_out_enable  = out_q.slave_output_enable;
	assign master_interrupt  = m_irq_q;
	assign slave_interrupt   = s_irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	start_sets_flags_a: assert property (
		m_start |=> m_en_q && m_pend_q)
		else $error("master start did not set enable and pending");

	stop_holds_count_a: assert property (
		!m_en_q && !unit_off && !m_start ##1 !unit_off |-> $stable(m_cnt_q))
		else $error("stopped master counter changed");

	master_reload_a: assert property (
		m_wrap |=> master_interrupt && (m_cnt_q == $past(mper_q)))
		else $error("master wrap without interrupt or reload");

	slave_oneshot_a: assert property (
		s_load1 |=> s_run_q && (s_cnt_q == $past(sduty_q)))
		else $error("type 1 slave not loaded on master interrupt");

	start_irq_mode_a: assert property (
		m_load && !mcfg_q.start_interrupt_mode_bit |=> !master_interrupt)
		else $error("start interrupt raised with mode bit clear");

	level_toggle_a: assert property (
		$changed(master_out_level) && !$past(wr_out) && !$past(unit_off)
		|-> master_interrupt)
		else $error("master level changed without interrupt");

	power_off_init_a: assert property (
		unit_off |=> (m_cnt_q == CNT_ZERO) && (s_cnt_q == CNT_ZERO) && !m_en_q && !s_en_q)
		else $error("unit off did not initialize channels");

	prescale_fast_a: assert property (
		unit_run && (psc_q[3:0] == 4'h0) |-> ck_tick[0])
		else $error("undivided count clock a missed a cycle");

	slave_down_end_a: assert property (
		s_fire && type2 && !s_up_q |-> s_cnt_q == CNT_ZERO ##1 slave_interrupt)
		else $error("down status slave interrupt at wrong count");

	slave_reload_a: assert property (
		s_carrier |=> !s_up_q && (s_cnt_q == $past(sduty_q)) && s_run_q)
		else $error("slave not reloaded at carrier start");

	cover_master_irq: cover property (m_wrap ##1 master_interrupt);
	cover_slave_up:   cover property (s_end_up && s_fire ##1 slave_interrupt);
	cover_stop:       cover property (m_en_q ##1 m_stop ##1 !m_en_q);

endmodule
